// [rtl/uart_fifo_ctl_regs.svh]
// Purpose: register offsets, field positions, reset values, levels
// Assumes: 32-bit APB data, one aligned word per register
// Notes: definitions only
`ifndef UART_FIFO_CTL_REGS_SVH
`define UART_FIFO_CTL_REGS_SVH

// ----------------------------------------
// register byte offsets
// ----------------------------------------
`define FC_OFF_CTRL 8'h00
`define FC_OFF_EVT 8'h04
`define FC_OFF_MASK 8'h08
`define FC_OFF_LEVEL 8'h0C

// ----------------------------------------
// fifo_control field positions
// ----------------------------------------
`define FC_BIT_EN 0
`define FC_BIT_TXCLR 2
`define FC_BIT_DMA 3
`define FC_TXTRIG_LSB 4
`define FC_RXTRIG_LSB 6

// ----------------------------------------
// event bit positions
// ----------------------------------------
`define FC_EV_RXTRIG 0
`define FC_EV_TXLOW 1
`define FC_EV_RXTO 2
`define FC_EV_TXCLR 3

// ----------------------------------------
// reset values
// ----------------------------------------
`define FC_TRIG_RST 2'h0
`define FC_MASK_RST 4'h0

// ----------------------------------------
// fifo depth and trigger levels
// ----------------------------------------
`define FC_DEPTH 6'h20
`define FC_RXLVL0 6'h08
`define FC_RXLVL1 6'h10
`define FC_RXLVL2 6'h18
`define FC_RXLVL3 6'h1C
`define FC_TXLVL0 6'h10
`define FC_TXLVL1 6'h08
`define FC_TXLVL2 6'h18
`define FC_TXLVL3 6'h1E

`endif

// [rtl/uart_fifo_ctl_pkg.sv]
// Purpose: types shared by the fifo control block and its bench
// Assumes: fill counts run 0 to 32
// Notes: all state of the block lives in ctl_state_s
package uart_fifo_ctl_pkg;

  // fill levels and strobes from the rest of the channel
  typedef struct packed {
    logic [5:0] tx_count; // transmit fifo or holding register fill
    logic [5:0] rx_count; // receive fifo or holding register fill
    logic thr_write;      // one character loaded into transmit_holding
    logic rx_timeout;     // receive time-out pulse
  } fifo_status_s;

  // complete register state of the block
  typedef struct packed {
    logic fifo_en;
    logic dma_mode;
    logic [1:0] tx_trig;
    logic [1:0] rx_trig;
    logic txclr;
    logic tx_rdy_n;
    logic rx_rdy_n;
    logic rx_hit;
    logic tx_low;
    logic [3:0] evt;
    logic [3:0] mask;
    logic [31:0] prdata;
  } ctl_state_s;

endpackage

// [rtl/uart_fifo_ctl.sv]
// Purpose: fifo_control register, trigger levels and dma ready pins
// Assumes: fill counts and strobes come from logic on pclk
// Notes: zero-wait apb slave; read data latched in setup phase
`timescale 1ns/1ps
`include "uart_fifo_ctl_regs.svh"

module uart_fifo_ctl (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire uart_fifo_ctl_pkg::fifo_status_s fifo_status,
  output logic fifo_enable,
  output logic dma_mode,
  output logic transmit_fifo_clear,
  output logic rx_trig_irq,
  output logic tx_empty_irq,
  output logic tx_dma_ready_n,
  output logic rx_dma_ready_n,
  output logic irq
);

  // ----------------------------------------
  // level lookups
  // ----------------------------------------

  // receive trigger code to byte count
  function automatic logic [5:0] rx_level(input logic [1:0] sel);
    case (sel)
      2'h0: rx_level = `FC_RXLVL0;
      2'h1: rx_level = `FC_RXLVL1;
      2'h2: rx_level = `FC_RXLVL2;
      default: rx_level = `FC_RXLVL3;
    endcase
  endfunction

  // transmit trigger code to byte count
  function automatic logic [5:0] tx_level(input logic [1:0] sel);
    case (sel)
      2'h0: tx_level = `FC_TXLVL0;
      2'h1: tx_level = `FC_TXLVL1;
      2'h2: tx_level = `FC_TXLVL2;
      default: tx_level = `FC_TXLVL3;
    endcase
  endfunction

  // ----------------------------------------
  // state and decode
  // ----------------------------------------
  uart_fifo_ctl_pkg::ctl_state_s q; // registered state
  uart_fifo_ctl_pkg::ctl_state_s d; // next state
  // apb phase decode
  logic setup;     // apb setup phase
  logic access;    // apb access phase
  logic mapped;    // address hits a register
  logic ctrl_wr;   // write to fifo_control
  logic mode1;     // block dma mode in force
  // trigger compares
  logic [5:0] rx_lvl; // selected receive level
  logic [5:0] tx_lvl; // selected transmit level
  logic rx_hit;    // receive fill at or past trigger
  logic tx_low;    // transmit fill below trigger
  logic [3:0] evt_set; // events this cycle

  assign setup = psel & ~penable;
  assign access = psel & penable;
  assign mapped = (paddr == `FC_OFF_CTRL) | (paddr == `FC_OFF_EVT) |
                  (paddr == `FC_OFF_MASK) | (paddr == `FC_OFF_LEVEL);
  assign ctrl_wr = access & pwrite & (paddr == `FC_OFF_CTRL);
  assign mode1 = q.fifo_en & q.dma_mode;
  assign rx_lvl = rx_level(q.rx_trig);
  assign tx_lvl = tx_level(q.tx_trig);
  // full 0..32 range, six-bit compare
  assign rx_hit = fifo_status.rx_count >= rx_lvl;
  assign tx_low = fifo_status.tx_count < tx_lvl;

  // rising edges of the level conditions, time-out, clear done
  assign evt_set = {q.txclr, fifo_status.rx_timeout,
                    tx_low & ~q.tx_low & q.fifo_en,
                    rx_hit & ~q.rx_hit & q.fifo_en};

  // ----------------------------------------
  // next-state logic
  // ----------------------------------------

  // registers, events and dma ready tracking
  always_comb begin
    d = q;
    d.txclr = 1'b0; // clear strobe lasts one cycle
    d.rx_hit = rx_hit;
    d.tx_low = tx_low;
    // fifo_control write
    if (ctrl_wr) begin
      d.fifo_en = pwdata[`FC_BIT_EN];
      // remaining fields only with enable in the same write
      if (pwdata[`FC_BIT_EN]) begin
        d.dma_mode = pwdata[`FC_BIT_DMA];
        d.tx_trig = pwdata[`FC_TXTRIG_LSB +: 2];
        d.rx_trig = pwdata[`FC_RXTRIG_LSB +: 2];
        d.txclr = pwdata[`FC_BIT_TXCLR];
      end
    end
    // mask write
    if (access & pwrite & (paddr == `FC_OFF_MASK)) begin
      d.mask = pwdata[3:0];
    end
    // event read clears; new event wins over the clear
    if (access & ~pwrite & (paddr == `FC_OFF_EVT)) begin
      d.evt = evt_set;
    end else begin
      d.evt = q.evt | evt_set;
    end
    // read data latched at setup
    if (setup & ~pwrite) begin
      case (paddr)
        `FC_OFF_CTRL: d.prdata = {24'h000000, q.rx_trig, q.tx_trig, q.dma_mode,
                                   q.txclr, 1'b0, q.fifo_en};
        `FC_OFF_EVT: d.prdata = {28'h0000000, q.evt};
        `FC_OFF_MASK: d.prdata = {28'h0000000, q.mask};
        `FC_OFF_LEVEL: d.prdata = {14'h0000, q.rx_rdy_n, q.tx_rdy_n, 2'h0,
                                    fifo_status.rx_count, 2'h0,
                                    fifo_status.tx_count};
        default: d.prdata = 32'h00000000;
      endcase
    end
    // transmit ready
    // mode 1: full releases, at or below trigger requests, else hold
    if (mode1) begin
      if (fifo_status.tx_count == `FC_DEPTH) begin
        d.tx_rdy_n = 1'b1;
      end else if (fifo_status.tx_count <= tx_lvl) begin
        d.tx_rdy_n = 1'b0;
      end
    end else begin
      // fifo off or mode 0: a load wins over empty
      if (fifo_status.thr_write) begin
        d.tx_rdy_n = 1'b1;
      end else if (fifo_status.tx_count == 6'h00) begin
        d.tx_rdy_n = 1'b0;
      end
    end
    // receive ready
    // mode 1: empty releases, trigger or time-out requests
    if (mode1) begin
      if (fifo_status.rx_count == 6'h00) begin
        d.rx_rdy_n = 1'b1;
      end else if (rx_hit | fifo_status.rx_timeout) begin
        d.rx_rdy_n = 1'b0;
      end
    end else begin
      // fifo off or mode 0: low while anything waits
      d.rx_rdy_n = fifo_status.rx_count == 6'h00;
    end
  end

  // ----------------------------------------
  // state register
  // ----------------------------------------

  // constants only under reset
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      q <= '0;
      q.tx_trig <= `FC_TRIG_RST;
      q.rx_trig <= `FC_TRIG_RST;
      q.mask <= `FC_MASK_RST;
      q.tx_rdy_n <= 1'b1;
      q.rx_rdy_n <= 1'b1;
    end else begin
      q <= d;
    end
  end

  // ----------------------------------------
  // outputs
  // ----------------------------------------
  assign prdata = q.prdata;
  // zero wait states; unmapped access flags an error
  assign pready = 1'b1;
  assign pslverr = access & ~mapped;
  assign fifo_enable = q.fifo_en;
  assign dma_mode = q.dma_mode;
  assign transmit_fifo_clear = q.txclr;
  // fifo interrupt levels drop while the fifos are off
  assign rx_trig_irq = q.rx_hit & q.fifo_en;
  assign tx_empty_irq = q.tx_low & q.fifo_en;
  assign tx_dma_ready_n = q.tx_rdy_n;
  assign rx_dma_ready_n = q.rx_rdy_n;
  assign irq = |(q.evt & q.mask);

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  a_txclr_pulse: assert property (
    ctrl_wr && pwdata[`FC_BIT_EN] && pwdata[`FC_BIT_TXCLR]
    |=> transmit_fifo_clear ##1 !transmit_fifo_clear)
    else $error("transmit clear not a single pulse");

  a_txclr_selfclr: assert property (
    transmit_fifo_clear && !ctrl_wr ##1 !ctrl_wr |-> !transmit_fifo_clear [*2])
    else $error("transmit clear bit did not self-clear");

  a_ctrl_gated: assert property (
    ctrl_wr && !pwdata[`FC_BIT_EN] |=> !transmit_fifo_clear && $stable(dma_mode))
    else $error("fields written without enable");

  a_mode_default: assert property (
    $rose(presetn) |-> !dma_mode)
    else $error("dma mode not 0 after reset");

  a_tx_default: assert property (
    q.tx_trig == 2'h0 |-> tx_lvl == 6'h10)
    else $error("default transmit level not 16");

  a_rx_irq: assert property (
    q.fifo_en && !ctrl_wr && fifo_status.rx_count == rx_lvl |=> rx_trig_irq)
    else $error("receive trigger interrupt missing");

  a_tx_irq: assert property (
    q.fifo_en && !ctrl_wr && fifo_status.tx_count < tx_lvl |=> tx_empty_irq)
    else $error("transmit empty interrupt missing");

  a_tx_m0_empty: assert property (
    !mode1 && fifo_status.tx_count == 6'h00 && !fifo_status.thr_write
    |=> !tx_dma_ready_n)
    else $error("tx ready not low when empty");

  a_tx_m0_write: assert property (
    !mode1 && fifo_status.thr_write |=> tx_dma_ready_n)
    else $error("tx ready not high after write");

  a_rx_m0_data: assert property (
    !mode1 && fifo_status.rx_count != 6'h00 |=> !rx_dma_ready_n)
    else $error("rx ready not low with data");

  a_rx_m0_empty: assert property (
    !mode1 && fifo_status.rx_count == 6'h00 |=> rx_dma_ready_n)
    else $error("rx ready not high when empty");

  a_tx_m1_full: assert property (
    mode1 && fifo_status.tx_count == 6'h20 |=> tx_dma_ready_n)
    else $error("tx ready not high when full");

  a_tx_m1_trig: assert property (
    mode1 && fifo_status.tx_count <= tx_lvl |=> !tx_dma_ready_n)
    else $error("tx ready not low at trigger");

  a_rx_m1_set: assert property (
    mode1 && fifo_status.rx_count != 6'h00 && (rx_hit || fifo_status.rx_timeout)
    |=> !rx_dma_ready_n)
    else $error("rx ready not low at trigger");

  a_rx_m1_hold: assert property (
    mode1 && !ctrl_wr && !rx_dma_ready_n && fifo_status.rx_count != 6'h00
    |=> !rx_dma_ready_n)
    else $error("rx ready released before empty");

  a_count_range: assert property (
    tx_lvl <= 6'h20 && rx_lvl <= 6'h20)
    else $error("trigger level beyond depth");

  // ----------------------------------------
  // event and bus checks
  // ----------------------------------------
  a_ctrl_readback: assert property (
    setup && !pwrite && paddr == `FC_OFF_CTRL && !q.txclr
    |=> !prdata[`FC_BIT_TXCLR])
    else $error("transmit clear bit read back as 1");

  a_level_read: assert property (
    setup && !pwrite && paddr == `FC_OFF_LEVEL
    |=> prdata[5:0] == $past(fifo_status.tx_count)
        && prdata[13:8] == $past(fifo_status.rx_count))
    else $error("level register read wrong");

  a_evt_sticky: assert property (
    q.evt[`FC_EV_RXTRIG] && !(access && !pwrite && paddr == `FC_OFF_EVT)
    |=> q.evt[`FC_EV_RXTRIG])
    else $error("receive trigger event lost before read");

  a_evt_rdclr: assert property (
    access && !pwrite && paddr == `FC_OFF_EVT && !evt_set[`FC_EV_TXLOW]
    |=> !q.evt[`FC_EV_TXLOW])
    else $error("transmit low event not cleared by read");

  a_txclr_event: assert property (
    transmit_fifo_clear |=> q.evt[`FC_EV_TXCLR])
    else $error("clear done event missing");

  a_tmo_event: assert property (
    fifo_status.rx_timeout |=> q.evt[`FC_EV_RXTO])
    else $error("time-out event missing");

  a_unmapped_wr: assert property (
    access && pwrite && !mapped
    |=> $stable(q.mask) && $stable(q.fifo_en) && $stable(q.rx_trig))
    else $error("write to unmapped address took effect");

  a_rx_lvl_top: assert property (
    q.rx_trig == 2'h3 |-> rx_lvl == 6'h1C)
    else $error("top receive level not 28");

  a_tx_lvl_top: assert property (
    q.tx_trig == 2'h3 |-> tx_lvl == 6'h1E)
    else $error("top transmit level not 30");

  // ----------------------------------------
  // scenario covers
  // ----------------------------------------
  c_mode1_rx: cover property (mode1 ##1 $fell(rx_dma_ready_n) ##[1:40] $rose(rx_dma_ready_n));
  c_mode1_tx: cover property (mode1 ##1 $fell(tx_dma_ready_n));
  c_mode0_tx: cover property (!mode1 && $fell(tx_dma_ready_n) ##[1:20] $rose(tx_dma_ready_n));
  c_txclr: cover property ($rose(transmit_fifo_clear));
  c_irq: cover property ($rose(irq));

endmodule

// [verification/uart_fifo_fill_model.sv]
// Purpose: far side model: fifo fill counts, host writes, time-outs
// Assumes: counts and pulses launched on the pclk rising edge
// Notes: bench loads counts directly; block clear empties tx side
`timescale 1ns/1ps

module uart_fifo_fill_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ld, // load both counts
  input wire logic [5:0] tx_ld,
  input wire logic [5:0] rx_ld,
  input wire logic wr_thr, // host writes one character
  input wire logic to_rx, // receive time-out
  input wire logic clr_tx, // transmit fifo clear from block
  output uart_fifo_ctl_pkg::fifo_status_s st
);
  // ----------------------------------------
  // fill counters
  // ----------------------------------------
  // pulses last one cycle, counts stay in 0..32
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= '0;
    end else begin
      st.thr_write <= wr_thr;
      st.rx_timeout <= to_rx;
      if (clr_tx) begin
        st.tx_count <= 6'h00;
      end else if (ld) begin
        st.tx_count <= tx_ld;
      end else if (wr_thr && st.tx_count != 6'h20) begin
        st.tx_count <= st.tx_count + 6'h01;
      end
      if (ld) begin
        st.rx_count <= rx_ld;
      end
    end
  end
endmodule

// [verification/test_uart_fifo_ctl.sv]
// Purpose: self-checking bench for the fifo control block
// Assumes: zero-wait apb slave, outputs one edge after inputs
// Notes: model adds one edge between a load and the block
`timescale 1ns/1ps
`include "uart_fifo_ctl_regs.svh"

module test_uart_fifo_ctl;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, er, fen, dma, clr, rxi, txi, txr_n, rxr_n, irq;
  logic ld = 1'b0, wr_thr = 1'b0, to_rx = 1'b0;
  logic [5:0] tx_ld = 6'h00, rx_ld = 6'h00;
  uart_fifo_ctl_pkg::fifo_status_s st;
  int err_total = 0, tests_run = 0;
  logic [5:0] rxl [4] = '{6'h08, 6'h10, 6'h18, 6'h1C}; // receive levels
  logic [5:0] txl [4] = '{6'h10, 6'h08, 6'h18, 6'h1E}; // transmit levels

  always #2 pclk = ~pclk;

  uart_fifo_ctl i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .fifo_status(st), .fifo_enable(fen), .dma_mode(dma),
    .transmit_fifo_clear(clr), .rx_trig_irq(rxi), .tx_empty_irq(txi),
    .tx_dma_ready_n(txr_n), .rx_dma_ready_n(rxr_n), .irq(irq));
  uart_fifo_fill_model i_far (.pclk(pclk), .presetn(presetn), .ld(ld), .tx_ld(tx_ld),
    .rx_ld(rx_ld), .wr_thr(wr_thr), .to_rx(to_rx), .clr_tx(clr), .st(st));

  // ----------------------------------------
  // shared tasks
  // ----------------------------------------
  // compare one value, count and report
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      err_total++;
      $display("Error %s expected %h seen %h", n, e, g);
    end
  endtask

  // one apb transfer: setup, then access until pready at an edge
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    // no bound here: the watchdog ends a hung wait
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  // load fill counts and let the block settle
  task automatic fill(input logic [5:0] t, input logic [5:0] r);
    @(posedge pclk);
    ld <= 1'b1;
    tx_ld <= t;
    rx_ld <= r;
    @(posedge pclk);
    ld <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  // one-cycle pulse on a far side strobe
  task automatic pulse(input logic transmit_holding);
    @(posedge pclk);
    if (transmit_holding) begin
      wr_thr <= 1'b1;
    end else begin
      to_rx <= 1'b1;
    end
    @(posedge pclk);
    wr_thr <= 1'b0;
    to_rx <= 1'b0;
    repeat (2) @(posedge pclk);
  endtask

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  // reset values, pins and the gated write
  task automatic t_reset();
    apb(1'b0, `FC_OFF_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd);
    chk("pready", 32'h1, pready);
    chk("ctrl err", 32'h0, er);
    chk("fifo en", 32'h0, fen);
    chk("dma", 32'h0, dma);
    apb(1'b0, `FC_OFF_MASK, 32'h0);
    chk("mask", 32'h0, rd);
    chk("tx_dma_ready_n", 32'h0, txr_n);
    chk("rx_dma_ready_n", 32'h1, rxr_n);
    chk("rx irq off", 32'h0, rxi);
    chk("tx irq off", 32'h0, txi);
    apb(1'b1, `FC_OFF_CTRL, 32'hFC);
    apb(1'b0, `FC_OFF_CTRL, 32'h0);
    chk("ctrl noen", 32'h0, rd);
    chk("dma noen", 32'h0, dma);
  endtask

  // every trigger code, one below and at the level
  task automatic t_levels();
    for (int i = 0; i < 4; i++) begin
      apb(1'b1, `FC_OFF_CTRL, 32'h01 | (i << 4) | (i << 6));
      fill(txl[i], rxl[i] - 6'h01);
      chk("rx irq lo", 32'h0, rxi);
      chk("tx irq lo", 32'h0, txi);
      fill(txl[i] - 6'h01, rxl[i]);
      chk("rx irq hi", 32'h1, rxi);
      chk("tx irq hi", 32'h1, txi);
    end
  endtask

  // single character dma signalling
  task automatic t_mode0();
    apb(1'b1, `FC_OFF_CTRL, 32'h01);
    fill(6'h00, 6'h00);
    chk("tx m0 empty", 32'h0, txr_n);
    pulse(1'b1);
    chk("tx m0 write", 32'h1, txr_n);
    fill(6'h00, 6'h01);
    chk("rx m0 data", 32'h0, rxr_n);
    fill(6'h00, 6'h00);
    chk("rx m0 empty", 32'h1, rxr_n);
  endtask

  // block dma signalling
  task automatic t_mode1();
    apb(1'b1, `FC_OFF_CTRL, 32'h09);
    fill(6'h20, 6'h00);
    chk("fen on", 32'h1, fen);
    chk("dma on", 32'h1, dma);
    chk("tx m1 full", 32'h1, txr_n);
    fill(6'h10, 6'h08);
    chk("tx m1 trig", 32'h0, txr_n);
    chk("rx m1 trig", 32'h0, rxr_n);
    fill(6'h14, 6'h01);
    chk("rx m1 hold", 32'h0, rxr_n);
    fill(6'h14, 6'h00);
    chk("rx m1 empty", 32'h1, rxr_n);
    fill(6'h14, 6'h01);
    chk("rx m1 below", 32'h1, rxr_n);
    pulse(1'b0);
    chk("rx m1 tmo", 32'h0, rxr_n);
  endtask

  // transmit clear, events, mask and unmapped access
  task automatic t_clear();
    apb(1'b1, `FC_OFF_MASK, 32'h8);
    apb(1'b0, `FC_OFF_EVT, 32'h0);
    apb(1'b1, `FC_OFF_CTRL, 32'h05);
    @(posedge pclk);
    chk("clr pulse", 32'h1, clr);
    @(posedge pclk);
    chk("clr end", 32'h0, clr);
    apb(1'b0, `FC_OFF_LEVEL, 32'h0);
    chk("tx cnt", 32'h0, rd[5:0]);
    chk("rx cnt", 32'h1, rd[13:8]);
    chk("ready bits", 32'h0, rd[17:16]);
    apb(1'b0, `FC_OFF_CTRL, 32'h0);
    chk("ctrl clr", 32'h01, rd);
    chk("irq set", 32'h1, irq);
    apb(1'b1, `FC_OFF_MASK, 32'h0);
    @(posedge pclk);
    chk("irq mask", 32'h0, irq);
    apb(1'b0, `FC_OFF_EVT, 32'h0);
    chk("evt clr", 32'h8, rd & 32'h8);
    apb(1'b0, `FC_OFF_EVT, 32'h0);
    chk("evt gone", 32'h0, rd & 32'h8);
    apb(1'b0, 8'h10, 32'h0);
    chk("unmapped err", 32'h1, er);
    chk("unmapped data", 32'h0, rd);
    apb(1'b1, 8'h10, 32'h0F);
    chk("unmapped wr err", 32'h1, er);
    apb(1'b0, `FC_OFF_MASK, 32'h0);
    chk("mask kept", 32'h0, rd);
  endtask

  // ----------------------------------------
  // verdict, main sequence, watchdog
  // ----------------------------------------
  task automatic results();
    $display("checks %0d errors %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask

  initial begin
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_levels();
    t_mode0();
    t_mode1();
    t_clear();
    results();
  end

  initial begin
    #100000;
    err_total++;
    results();
  end
endmodule
